// ===== hw/lcdfr_consts.svh
`ifndef LCDFR_CONSTS_SVH
`define LCDFR_CONSTS_SVH
// register indices; byte address is four times the index
`define LCDFR_FRR_IDX 8'hE6
`define LCDFR_CCR_IDX 8'hE7
`define LCDFR_CFG_IDX 8'hE8
`define LCDFR_STA_IDX 8'hE9
// reset values
`define LCDFR_FRR_RST 8'h00
`define LCDFR_CCR_RST 8'h00
`define LCDFR_CFG_RST 8'h00
// frame rate register fields
`define LCDFR_PS_LSB 4
`define LCDFR_CD_LSB 0
// drive and contrast register fields
`define LCDFR_DC_LSB 5
`define LCDFR_MDT_BIT 4
`define LCDFR_CC_LSB 0
// configuration register fields
`define LCDFR_BL_BIT 0
`define LCDFR_DUTY_LSB 4
`define LCDFR_CS_BIT 7
// status register fields
`define LCDFR_ST_BL_BIT 0
`define LCDFR_ST_DRV_BIT 1
`define LCDFR_ST_PCLK_BIT 2
`define LCDFR_ST_CC_LSB 4
// half of the prescaler tap: code 0 gives 16, others 32 << code
`define LCDFR_HALF_TAP0 12'h008
`define LCDFR_HALF_BASE 12'h010
// panel clock periods per frame
`define LCDFR_K_STD 4'h8
`define LCDFR_K_THIRD 4'h6
// clock rate and nominal drive times
`define LCDFR_CLK_MHZ 40
`define LCDFR_DRV0_US 300
`define LCDFR_DRV1_US 70
`define LCDFR_DRV2_US 150
`define LCDFR_DRV3_US 450
`define LCDFR_DRV4_US 575
`define LCDFR_DRV5_US 850
`define LCDFR_DRV6_US 1150
`define LCDFR_DC_HALF 3'h7
`endif

// ===== hw/lcdfr_pkg.sv
package lcdfr_pkg;
   // duty selection codes
   typedef enum logic [1:0] {
      DUTY_STATIC = 2'h0,
      DUTY_HALF = 2'h1,
      DUTY_THIRD = 2'h2,
      DUTY_QUARTER = 2'h3
   } lcdfr_duty_e;
   // driver window states, gray along off -> on -> done
   typedef enum logic [1:0] {
      DRV_OFF = 2'h0,
      DRV_ON = 2'h1,
      DRV_DONE = 2'h3
   } lcdfr_drv_e;
   // whole state of the timing block
   typedef struct packed {
      logic [2:0] ps; logic [2:0] cd; logic [2:0] dc; logic mdt;
      logic [3:0] cc; lcdfr_duty_e duty; logic cs; logic blReq;
      logic [3:0] ccAct; logic blAct;
      logic extS1; logic extS2; logic extPrev;
      logic [11:0] preCnt; logic [2:0] divCnt; logic panelClk;
      logic [3:0] frmCnt; logic frameStrobe;
      lcdfr_drv_e drv; logic [15:0] drvCnt; logic driverOn;
      logic dpWr; logic dpOk; logic [7:0] dpIdx;
      logic [31:0] hrdata; logic hready;
      logic [15:0] perCnt; logic perValid;
      logic [19:0] frmPer; logic frmValid;
   } lcdfr_state_s;
endpackage

// ===== hw/lcdfr_timing.sv
// Contract
// RL1 - reserved frame rate bits 7, 3 read zero
// RL2 - prescaler code picks tap 16 to 4096
// RL3 - divide prescaler output by code plus one
// RL4 - panel clock is source over N times D
// RL5 - frame is 8*N*D for 1/4, 1/2, static
// RL6 - frame is 6*N*D for 1/3 duty
// RL7 - drive code picks nominal driver on-time
// RL8 - on-time never exceeds half panel period
// RL9 - static or blanking forces half period on-time
// RL10 - max drive bit keeps drivers always on
// RL11 - contrast code maps linearly onto drive level
// RL12 - new contrast applies at next frame start
// RL13 - mux field selects static, 1/2, 1/3, 1/4
// RL14 - source clock: system or external clock
// RL15 - blanking takes effect when frame completes
// RL16 - frame strobe loads frame-synchronous settings
//
// The AHB-Lite slave port was decided locally.
`include "lcdfr_consts.svh"

module lcdfr_timing import lcdfr_pkg::*; #(
   parameter int DRV0_CYC = `LCDFR_DRV0_US * `LCDFR_CLK_MHZ,
   parameter int DRV1_CYC = `LCDFR_DRV1_US * `LCDFR_CLK_MHZ,
   parameter int DRV2_CYC = `LCDFR_DRV2_US * `LCDFR_CLK_MHZ,
   parameter int DRV3_CYC = `LCDFR_DRV3_US * `LCDFR_CLK_MHZ,
   parameter int DRV4_CYC = `LCDFR_DRV4_US * `LCDFR_CLK_MHZ,
   parameter int DRV5_CYC = `LCDFR_DRV5_US * `LCDFR_CLK_MHZ,
   parameter int DRV6_CYC = `LCDFR_DRV6_US * `LCDFR_CLK_MHZ
) (
   input wire logic ref_clk, // system clock, 40 MHz
   input wire logic resetn, // async reset, active low
   input wire logic extClk, // external asynchronous lcd source
   input wire logic hsel, // ahb slave select
   input wire logic [31:0] haddr, // ahb address
   input wire logic [1:0] htrans, // ahb transfer type
   input wire logic hwrite, // ahb write
   input wire logic [2:0] hsize, // ahb size, word only
   input wire logic [31:0] hwdata, // ahb write data
   input wire logic hready, // ahb bus ready
   output logic [31:0] hrdata, // ahb read data
   output logic hreadyout, // ahb slave ready
   output logic hresp, // ahb response, always okay
   output logic prescaledPanelClock, // prescaled panel clock
   output logic frameStart, // one-cycle frame start strobe
   output logic driverOn, // lcd drivers enabled
   output logic [3:0] contrastLevel, // active contrast code
   output logic displayBlanked // segments and commons grounded
);

   lcdfr_state_s q; // registered state
   lcdfr_state_s d; // next state
   logic srcTick; // one lcd source clock cycle
   logic halfTick; // half panel period elapsed
   logic rise; // panel clock rising this cycle
   logic fall; // panel clock falling this cycle
   logic frmTick; // last panel period of the frame ends
   logic fullHalf; // on-time forced to half a period
   logic addrPhase; // ahb address phase taken
   logic cfgWrite; // write to a timing setting
   logic [7:0] rdByte; // read mux result

   // half of the prescaler divide ratio for a code
   function automatic logic [11:0] tapHalf(input logic [2:0] ps);
      if (ps == 3'h0) begin
         return `LCDFR_HALF_TAP0;
      end
      return `LCDFR_HALF_BASE << ps;
   endfunction

   // panel periods per frame from the duty
   function automatic logic [3:0] kOf(input lcdfr_duty_e duty);
      return (duty == DUTY_THIRD) ? `LCDFR_K_THIRD : `LCDFR_K_STD;
   endfunction

   // nominal on-time in system clock cycles
   function automatic logic [15:0] drvCycles(input logic [2:0] dc);
      case (dc)
         3'h0: return 16'(DRV0_CYC);
         3'h1: return 16'(DRV1_CYC);
         3'h2: return 16'(DRV2_CYC);
         3'h3: return 16'(DRV3_CYC);
         3'h4: return 16'(DRV4_CYC);
         3'h5: return 16'(DRV5_CYC);
         3'h6: return 16'(DRV6_CYC);
         default: return 16'hFFFF; // half period ends it first
      endcase
   endfunction

   // next-state logic for the whole block
   always_comb begin
      d = q;
      d.frameStrobe = 1'b0;
      // external clock is sampled twice before use
      d.extS1 = extClk;
      d.extS2 = q.extS1;
      d.extPrev = q.extS2;
      // source is every system cycle or each external rise
      srcTick = q.cs ? (q.extS2 & ~q.extPrev) : 1'b1; // [RL14]
      halfTick = 1'b0;
      // prescaler then divider; >= copes with a smaller new code
      if (srcTick) begin
         if (q.preCnt >= tapHalf(q.ps) - 12'h001) begin // [RL2]
            d.preCnt = 12'h000;
            if (q.divCnt >= q.cd) begin // [RL3]
               d.divCnt = 3'h0;
               halfTick = 1'b1;
            end else begin
               d.divCnt = q.divCnt + 3'h1;
            end
         end else begin
            d.preCnt = q.preCnt + 12'h001;
         end
      end
      rise = halfTick & ~q.panelClk;
      fall = halfTick & q.panelClk;
      // toggling each half period gives a full period of N*D
      if (halfTick) begin
         d.panelClk = ~q.panelClk; // [RL4]
      end
      // frame counts K panel periods
      frmTick = 1'b0;
      if (rise) begin
         if (q.frmCnt >= kOf(q.duty) - 4'h1) begin // [RL5] [RL6] [RL13]
            d.frmCnt = 4'h0;
            frmTick = 1'b1;
         end else begin
            d.frmCnt = q.frmCnt + 4'h1;
         end
      end
      // frame-synchronous settings load with the strobe
      if (frmTick) begin
         d.frameStrobe = 1'b1; // [RL16]
         d.ccAct = q.cc; // [RL12] [RL11]
         d.blAct = q.blReq; // [RL15]
      end
      // driver window opens at each panel clock rise
      fullHalf = (q.dc == `LCDFR_DC_HALF) | (q.duty == DUTY_STATIC)
         | q.blAct; // [RL9]
      case (q.drv)
         DRV_OFF: begin
            if (rise) begin
               d.drv = DRV_ON;
               d.drvCnt = 16'h0000;
            end
         end
         DRV_ON: begin
            if (fall) begin
               d.drv = DRV_OFF; // [RL8]
            // exact match: a code shortened mid-window or a lifted
            // forced half lets this window run on to the fall instead
            end else if (!fullHalf &&
                         q.drvCnt == drvCycles(q.dc) - 16'h0001) begin
               d.drv = DRV_DONE; // [RL7]
            end else begin
               d.drvCnt = q.drvCnt + 16'h0001;
            end
         end
         DRV_DONE: begin
            if (fall) begin
               d.drv = DRV_OFF;
            end
         end
         default: begin
            d.drv = DRV_OFF;
         end
      endcase
      // data phase of a write lands in the registers
      cfgWrite = 1'b0;
      if (q.dpWr && q.dpOk) begin
         case (q.dpIdx)
            `LCDFR_FRR_IDX: begin
               d.ps = hwdata[`LCDFR_PS_LSB +: 3];
               d.cd = hwdata[`LCDFR_CD_LSB +: 3];
               cfgWrite = 1'b1;
            end
            `LCDFR_CCR_IDX: begin
               d.dc = hwdata[`LCDFR_DC_LSB +: 3];
               d.mdt = hwdata[`LCDFR_MDT_BIT];
               d.cc = hwdata[`LCDFR_CC_LSB +: 4];
            end
            `LCDFR_CFG_IDX: begin
               d.blReq = hwdata[`LCDFR_BL_BIT];
               d.duty = lcdfr_duty_e'(hwdata[`LCDFR_DUTY_LSB +: 2]);
               d.cs = hwdata[`LCDFR_CS_BIT];
               cfgWrite = 1'b1;
            end
            default: begin
               cfgWrite = 1'b0; // unmapped writes are dropped
            end
         endcase
      end
      d.driverOn = d.mdt | (d.drv == DRV_ON); // [RL10]
      // address phase; read data is built from the updated copy
      addrPhase = hsel & htrans[1] & hready;
      rdByte = 8'h00;
      case (haddr[9:2])
         `LCDFR_FRR_IDX: begin
            rdByte[`LCDFR_PS_LSB +: 3] = d.ps; // [RL1]
            rdByte[`LCDFR_CD_LSB +: 3] = d.cd;
         end
         `LCDFR_CCR_IDX: begin
            rdByte = {d.dc, d.mdt, d.cc};
         end
         `LCDFR_CFG_IDX: begin
            rdByte[`LCDFR_BL_BIT] = d.blReq;
            rdByte[`LCDFR_DUTY_LSB +: 2] = d.duty;
            rdByte[`LCDFR_CS_BIT] = d.cs;
         end
         `LCDFR_STA_IDX: begin
            rdByte[`LCDFR_ST_BL_BIT] = d.blAct;
            rdByte[`LCDFR_ST_DRV_BIT] = d.driverOn;
            rdByte[`LCDFR_ST_PCLK_BIT] = d.panelClk;
            rdByte[`LCDFR_ST_CC_LSB +: 4] = d.ccAct;
         end
         default: begin
            rdByte = 8'h00; // unmapped reads as zero
         end
      endcase
      d.dpWr = addrPhase & hwrite;
      d.dpOk = haddr[31:10] == 22'h000000;
      d.dpIdx = haddr[9:2];
      if (addrPhase && !hwrite) begin
         d.hrdata = d.dpOk ? {24'h000000, rdByte} : 32'h00000000;
      end
      // period measurement kept only for the checks below
      d.perCnt = rise ? 16'h0000 : q.perCnt + 16'h0001;
      d.frmPer = frmTick ? 20'h00000 : q.frmPer + 20'h00001;
      if (rise) begin
         d.perValid = 1'b1;
      end
      if (frmTick) begin
         d.frmValid = 1'b1;
      end
      if (cfgWrite) begin
         d.perValid = 1'b0;
         d.frmValid = 1'b0;
      end
   end

   // state register
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         q <= '0;
         q.ps <= 3'(`LCDFR_FRR_RST >> `LCDFR_PS_LSB);
         q.cd <= 3'(`LCDFR_FRR_RST >> `LCDFR_CD_LSB);
         q.dc <= 3'(`LCDFR_CCR_RST >> `LCDFR_DC_LSB);
         q.cc <= 4'(`LCDFR_CCR_RST >> `LCDFR_CC_LSB);
         q.duty <= lcdfr_duty_e'(2'(`LCDFR_CFG_RST >> `LCDFR_DUTY_LSB));
         q.drv <= DRV_OFF;
         q.hready <= 1'b1; // zero wait states, always ready
      end else begin
         q <= d;
      end
   end

   // outputs straight from the state register, hresp tied to okay
   assign hrdata = q.hrdata;
   assign hreadyout = q.hready;
   assign hresp = 1'b0;
   assign prescaledPanelClock = q.panelClk;
   assign frameStart = q.frameStrobe;
   assign driverOn = q.driverOn;
   assign contrastLevel = q.ccAct;
   assign displayBlanked = q.blAct;

   // read of the frame rate register
   sequence s_frr_read;
      hsel && htrans[1] && hready && !hwrite &&
         haddr == {22'h000000, `LCDFR_FRR_IDX, 2'h0};
   endsequence

   // a settled panel period on the system clock
   sequence s_clean_rise;
      rise && q.perValid && !q.cs;
   endsequence

   chk_frr_reserved: assert property (@(posedge ref_clk) // [RL1]
      disable iff (!resetn) s_frr_read |=> !hrdata[7] && !hrdata[3])
      else $error("reserved frame rate bits read nonzero");
   chk_panel_period: assert property (@(posedge ref_clk) // [RL2] [RL4]
      disable iff (!resetn) s_clean_rise |->
         int'(q.perCnt) + 1 == 2 * int'(tapHalf(q.ps)) * (int'(q.cd) + 1))
      else $error("panel clock period is not N times D");
   chk_frame_period: assert property (@(posedge ref_clk) // [RL5] [RL6]
      disable iff (!resetn) frmTick && q.frmValid && !q.cs |->
         int'(q.frmPer) + 1 == int'(kOf(q.duty)) * 2 *
         int'(tapHalf(q.ps)) * (int'(q.cd) + 1))
      else $error("frame period is not K times N times D");
   chk_src_hold: assert property (@(posedge ref_clk) // [RL14]
      disable iff (!resetn) q.cs && !(q.extS2 && !q.extPrev) |=>
         $stable(q.preCnt))
      else $error("prescaler moved without an external edge");
   chk_contrast_sync: assert property (@(posedge ref_clk) // [RL12]
      disable iff (!resetn) $changed(q.ccAct) |-> q.frameStrobe)
      else $error("contrast changed away from a frame start");
   chk_contrast_load: assert property (@(posedge ref_clk) // [RL16]
      disable iff (!resetn) q.frameStrobe |-> q.ccAct == $past(q.cc))
      else $error("frame start did not load the contrast code");
   chk_blank_sync: assert property (@(posedge ref_clk) // [RL15]
      disable iff (!resetn) $changed(q.blAct) |-> q.frameStrobe)
      else $error("blanking changed away from a frame start");
   chk_max_drive: assert property (@(posedge ref_clk) // [RL10]
      disable iff (!resetn) q.mdt |-> q.driverOn)
      else $error("drivers off while max drive set");
   chk_half_limit: assert property (@(posedge ref_clk) // [RL8]
      disable iff (!resetn) q.driverOn && !q.mdt |-> q.panelClk)
      else $error("driver on beyond half a panel period");
   chk_forced_half: assert property (@(posedge ref_clk) // [RL9]
      disable iff (!resetn) $rose(q.panelClk) && fullHalf && !q.mdt
         |-> q.driverOn)
      else $error("forced half period on-time not applied");
   chk_nominal_time: assert property (@(posedge ref_clk) // [RL7]
      disable iff (!resetn) $fell(q.driverOn) && q.panelClk && !q.mdt
         |-> q.drvCnt == drvCycles(q.dc) - 16'h0001)
      else $error("driver on-time differs from nominal");

endmodule // lcdfr_timing

// ===== testbench/lcd_frame_rate_and_drive_control_test.sv
`include "lcdfr_consts.svh"

module lcd_frame_rate_and_drive_control_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, resetn, extClk, hsel, hwrite, hready; // bus and clocks
   logic [31:0] haddr, hwdata, hrdata, rd; // bus data, last read
   logic [1:0] htrans; // transfer type
   logic [2:0] hsize; // word only
   logic hreadyout, hresp, panelClk, frameStart, driverOn, blanked;
   logic [3:0] contrast; // active contrast code
   int nMismatch, totalChecks, h, l, c; // counters and scratch
   int tp[7] = '{0, 0, 1, 0, 0, 2, 0}; // prescaler codes
   int tc[7] = '{0, 0, 1, 7, 4, 0, 0}; // divide codes
   int td[7] = '{0, 2, 1, 3, 2, 2, 0}; // duty codes
   // drive times in cycles: five shortened, two at their default
   int nom[8] = '{5, 2, 3, 6, 7, `LCDFR_DRV5_US * `LCDFR_CLK_MHZ,
      `LCDFR_DRV6_US * `LCDFR_CLK_MHZ, 8};

   assign hready = hreadyout; // single slave owns the bus ready

   lcdfr_timing #(.DRV0_CYC(5), .DRV1_CYC(2), .DRV2_CYC(3), .DRV3_CYC(6),
      .DRV4_CYC(7)) lcdfr_timing_i (
      .ref_clk(ref_clk), .resetn(resetn), .extClk(extClk), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp),
      .prescaledPanelClock(panelClk), .frameStart(frameStart),
      .driverOn(driverOn), .contrastLevel(contrast),
      .displayBlanked(blanked));

   // system clock, 40 MHz
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   // external source, six system periods, edges only on falling system edges
   initial begin
      extClk = 1'b0;
      forever #75 extClk = ~extClk;
   end

   // verdict, the one place the run ends
   task automatic finalReport();
      $display("checks %0d mismatches %0d", totalChecks, nMismatch);
      if (nMismatch == 0 && totalChecks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // value compare, case equality so unknowns never match
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      totalChecks++;
      if (g !== e) begin
         nMismatch++;
         $display("ERROR %s expected %0h seen %0h", nm, e, g);
      end
   endtask

   // a used-up bound counts as a mismatch and ends the run
   task automatic tmo(input int n, input int lim);
      if (n >= lim) begin
         nMismatch++;
         $display("ERROR timeout expected %0d seen %0d", lim - 1, n);
         finalReport();
      end
   endtask

   // selects the watched output
   function automatic logic sig(input int s);
      case (s)
         0: return frameStart;
         1: return panelClk;
         default: return driverOn;
      endcase
   endfunction

   // wait for a level, sampled at the falling edge where it is settled
   task automatic waitFor(input int s, input logic lvl);
      int n;
      n = 0;
      do begin @(negedge ref_clk); n++; end
      while (sig(s) !== lvl && n < 20000);
      tmo(n, 20000);
   endtask

   // cycles the level lasts, counted from a cycle where it was seen
   task automatic runLen(input int s, input logic lvl, output int n);
      n = 0;
      do begin @(negedge ref_clk); n++; end
      while (sig(s) === lvl && n < 20000);
      tmo(n, 20000);
   endtask

   // one single word transfer; holds each phase until ready is seen
   task automatic bus(input logic w, input logic [7:0] idx,
                      input logic [7:0] wd);
      int n;
      @(posedge ref_clk);
      hsel <= 1'b1;
      haddr <= {22'h0, idx, 2'h0};
      htrans <= 2'h2;
      hwrite <= w;
      n = 0;
      do begin @(posedge ref_clk); n++; end
      while (hready !== 1'b1 && n < 50);
      tmo(n, 50);
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      n = 0;
      do begin @(posedge ref_clk); n++; end
      while (hready !== 1'b1 && n < 50);
      tmo(n, 50);
      rd = hrdata;
   endtask

   task automatic rdChk(input string nm, input logic [7:0] idx,
                        input logic [31:0] e);
      bus(1'b0, idx, 8'h00);
      chk(nm, e, rd);
   endtask

   // frame gap and strobe width, then panel clock high time
   task automatic frameCase(input int n, input int d, input int k);
      waitFor(0, 1'b1);
      runLen(0, 1'b1, h);
      runLen(0, 1'b0, l);
      chk("strobe width", 1, h);
      chk("frame gap", k * n * d, h + l);
      waitFor(1, 1'b0);
      waitFor(1, 1'b1);
      runLen(1, 1'b1, h);
      chk("panel half", n * d / 2, h);
   endtask

   // on-time of the next driver window
   task automatic drvCase(input int e);
      waitFor(2, 1'b0);
      waitFor(2, 1'b1);
      runLen(2, 1'b1, h);
      chk("drive time", e, h);
   endtask

   // hang guard, well above the longest sequence
   initial begin
      #2500000;
      tmo(1, 1);
   end

   initial begin
      resetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      nMismatch = 0;
      totalChecks = 0;
      void'($urandom(32'h9031C542));
      repeat (5) @(posedge ref_clk);
      resetn <= 1'b1;
      // reset values, reserved bits and an unmapped word
      rdChk("frr reset", `LCDFR_FRR_IDX, 32'h0);
      rdChk("ccr reset", `LCDFR_CCR_IDX, 32'h0);
      bus(1'b1, `LCDFR_FRR_IDX, 8'hFF);
      rdChk("frr reserved", `LCDFR_FRR_IDX, 32'h77);
      bus(1'b1, 8'h10, 8'hA5);
      rdChk("unmapped", 8'h10, 32'h0);
      // divider table, last row random within the short taps
      tp[6] = $urandom % 2;
      tc[6] = $urandom % 8;
      td[6] = $urandom % 4;
      for (int i = 0; i < 7; i++) begin
         bus(1'b1, `LCDFR_CFG_IDX, 8'(td[i] << 4));
         bus(1'b1, `LCDFR_FRR_IDX, 8'((tp[i] << 4) | tc[i]));
         frameCase(tp[i] == 0 ? 16 : 32 << tp[i], tc[i] + 1,
                   td[i] == 2 ? 6 : 8);
      end
      // external source: six system cycles per source tick
      bus(1'b1, `LCDFR_CFG_IDX, 8'hB0);
      bus(1'b1, `LCDFR_FRR_IDX, 8'h00);
      frameCase(16 * 6, 1, 8);
      // every drive code at quarter duty; half period is 8 cycles
      bus(1'b1, `LCDFR_CFG_IDX, 8'h30);
      for (int i = 0; i < 8; i++) begin
         bus(1'b1, `LCDFR_CCR_IDX, 8'(i << 5));
         drvCase(nom[i] < 8 ? nom[i] : 8);
      end
      // contrast holds until the next strobe, then takes the new code
      c = $urandom % 15 + 1;
      waitFor(0, 1'b1);
      bus(1'b1, `LCDFR_CCR_IDX, 8'(32 | c));
      chk("contrast hold", 32'h0, 32'(contrast));
      waitFor(0, 1'b1);
      chk("contrast new", 32'(c), 32'(contrast));
      rdChk("ccr back", `LCDFR_CCR_IDX, 32'(32 | c));
      // static duty forces a full half period
      bus(1'b1, `LCDFR_CFG_IDX, 8'h00);
      drvCase(8);
      // blanking waits for the frame to complete
      bus(1'b1, `LCDFR_CFG_IDX, 8'h30);
      waitFor(0, 1'b1);
      bus(1'b1, `LCDFR_CFG_IDX, 8'h31);
      chk("blank early", 32'h0, 32'(blanked));
      waitFor(0, 1'b1);
      chk("blank frame", 32'h1, 32'(blanked));
      drvCase(8);
      // max drive keeps the drivers on through whole periods
      bus(1'b1, `LCDFR_CCR_IDX, 8'h30);
      h = 0;
      repeat (40) begin
         @(negedge ref_clk);
         if (driverOn === 1'b1) h++;
      end
      chk("max drive", 40, h);
      finalReport();
   end
endmodule // lcd_frame_rate_and_drive_control_test
